// ### logic/sfr_bank.sv
// Special function registers of the 8-bit core: indirect port,
// timer, program counter and stack, status, ports, power control.
// Assumes the core gives one i_icyc pulse per instruction and
// presents its register reads, writes and flow commands with it.
// Behaviour
// RULE1 - Address zero has no storage; access goes to pointer target.
// RULE2 - Indirect read with pointer zero returns zero.
// RULE3 - Indirect write with pointer zero changes nothing but flags.
// RULE4 - Low six pointer bits form the indirect address, 64 registers.
// RULE5 - Upper two pointer bits read as one.
// RULE6 - Timer counts instruction cycles or pin edges by source select.
// RULE7 - Edge select picks rising or falling pin edge.
// RULE8 - Prescaler given to timer when bit clear; timer write clears it.
// RULE9 - Ten-bit program counter with five-entry return stack.
// RULE10 - Counter advances by one per instruction unless loaded.
// RULE11 - Jump loads all ten bits; buffer unchanged.
// RULE12 - Call pushes next address then loads target; buffer unchanged.
// RULE13 - All three returns pop the counter; buffer unchanged.
// RULE14 - Low byte write takes high bits from buffer, never reverse.
// RULE15 - Flag-affecting write to status blocks low flags; reset flags fixed.
// RULE16 - Carry from add, no-borrow on subtract, shifted bit on rotate.
// RULE17 - Digit carry from bit three, no-borrow on subtract.
// RULE18 - Zero flag tracks a zero result.
// RULE19 - Power-down set at power-up and clear-watchdog, cleared by sleep.
// RULE20 - Timeout set at power-up, clear-watchdog, sleep; cleared by overflow.
// RULE21 - Port reads show pins; writes go to output latches.
// RULE22 - Interrupt select routes port B pin 0 to interrupt or change path.
// RULE23 - Power control holds watchdog, detector, resistor enables; low nibble zero.

`timescale 1ns/1ps

module sfr_bank (
  input  wire  logic             i_clk,
  input  wire  logic             i_rstn,
  input  wire  logic             i_icyc,
  input  wire  logic             i_rd,
  input  wire  logic [5:0]       i_rd_addr,
  input  wire  logic             i_wr,
  input  wire  logic [5:0]       i_wr_addr,
  input  wire  logic [7:0]       i_wr_data,
  input  wire  logic             i_opt_wr,
  input  wire  logic [7:0]       i_opt_data,
  input  wire  logic             i_jump,
  input  wire  logic             i_call,
  input  wire  logic             i_ret,
  input  wire  logic [9:0]       i_target,
  input  wire  sfr_pkg::sfr_alu_t i_alu_kind,
  input  wire  logic [7:0]       i_alu_a,
  input  wire  logic [7:0]       i_alu_b,
  input  wire  logic [7:0]       i_alu_res,
  input  wire  logic             i_clear_watchdog_instruction,
  input  wire  logic             i_sleep,
  input  wire  logic             i_wdt_ovf,
  input  wire  logic             i_tmr_pin,
  input  wire  logic [7:0]       i_pa_pins,
  input  wire  logic [7:0]       i_pb_pins,
  output logic       [7:0]       o_rd_data,
  output logic       [9:0]       o_pc,
  output logic       [7:0]       o_status,
  output logic                   o_tmr_ovf,
  output logic       [7:0]       o_pa_latch,
  output logic       [7:0]       o_pb_latch,
  output logic                   o_wdt_en,
  output logic                   o_lvd_en,
  output logic                   o_roc_en,
  output logic                   o_ext_int,
  output logic       [7:0]       o_pb_chg_mask
);
  import sfr_pkg::*;

  sfr_state_t s_r;
  sfr_state_t s_nxt;

  logic [5:0] rd_ea;
  logic [5:0] wr_ea;
  logic [7:0] rd_val;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic [7:0] ps_mask;
  logic       pin_edge;
  logic       src_tick;
  logic       tmr_inc;
  logic       flags_hit;
  logic       gpr_rd;
  logic       gpr_wr;

  ////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s_r;
    s_nxt.tmr_ovf = 1'b0;

    // Address zero is a window onto the pointer target
    rd_ea = (i_rd_addr == A_IND) ? s_r.ptr[5:0] : i_rd_addr; // see RULE1 see RULE4
    wr_ea = (i_wr_addr == A_IND) ? s_r.ptr[5:0] : i_wr_addr; // see RULE1 see RULE4
    gpr_rd = (rd_ea == A_GPR0) || (rd_ea >= A_GPR_LO);
    gpr_wr = (wr_ea == A_GPR0) || (wr_ea >= A_GPR_LO);

    // Read path
    rd_val = 8'h00;
    case (rd_ea)
      A_IND:   rd_val = 8'h00; // see RULE2
      A_TMR:   rd_val = s_r.tmr;
      A_PCL:   rd_val = s_r.pc[7:0];
      A_STAT:  rd_val = s_r.stat;
      A_PTR:   rd_val = s_r.ptr | PTR_ONES; // see RULE5
      A_PA:    rd_val = i_pa_pins; // see RULE21
      A_PB:    rd_val = i_pb_pins; // see RULE21
      A_POWER_CONTROL:  rd_val = s_r.power_control & POWER_CONTROL_MASK; // see RULE23
      A_PCHB:  rd_val = s_r.pchb & PCHB_MASK;
      default: rd_val = gpr_rd ? s_r.gpr[rd_ea] : 8'h00;
    endcase
    if (i_rd) begin
      s_nxt.rd_data = rd_val;
    end

    // Operand arithmetic; subtract adds the two's complement
    sum9  = 9'h000;
    half5 = 5'h00;
    if (i_alu_kind == ALU_SUB) begin
      sum9  = {1'b0, i_alu_a} + {1'b0, ~i_alu_b} + 9'h001; // see RULE16
      half5 = {1'b0, i_alu_a[3:0]} + {1'b0, ~i_alu_b[3:0]} + 5'h01; // see RULE17
    end else begin
      sum9  = {1'b0, i_alu_a} + {1'b0, i_alu_b}; // see RULE16
      half5 = {1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]}; // see RULE17
    end

    // Timer clocking and prescaler
    if (i_opt_wr) begin
      s_nxt.opt = i_opt_data;
    end
    s_nxt.pin_prev = i_tmr_pin;
    pin_edge = s_r.opt[OPT_SE] ? (s_r.pin_prev && !i_tmr_pin)
                               : (!s_r.pin_prev && i_tmr_pin); // see RULE7
    src_tick = s_r.opt[OPT_CS] ? pin_edge : i_icyc; // see RULE6
    ps_mask  = 8'((9'h002 << s_r.opt[2:0]) - 9'h001);
    tmr_inc  = 1'b0;
    if (!s_r.opt[OPT_PA]) begin
      if (src_tick) begin
        if (s_r.presc == ps_mask) begin
          s_nxt.presc = 8'h00;
          tmr_inc = 1'b1;
        end else begin
          s_nxt.presc = s_r.presc + 8'h01;
        end
      end
    end else begin
      tmr_inc = src_tick;
    end
    if (tmr_inc) begin
      s_nxt.tmr = s_r.tmr + 8'h01;
      s_nxt.tmr_ovf = (s_r.tmr == 8'hff);
    end

    // Register writes
    flags_hit = (i_alu_kind != ALU_NONE);
    if (i_wr) begin
      case (wr_ea)
        A_IND: begin
          // Pointer aimed at address zero: write is dropped
        end // see RULE3
        A_TMR: begin
          s_nxt.tmr = i_wr_data;
          s_nxt.tmr_ovf = 1'b0;
          if (!s_r.opt[OPT_PA]) begin
            s_nxt.presc = 8'h00; // see RULE8
          end
        end
        A_PCL: begin
          // Loaded through the counter path below
        end
        A_STAT: begin
          s_nxt.stat[7:5] = i_wr_data[7:5]; // see RULE15
          if (!flags_hit) begin
            s_nxt.stat[2:0] = i_wr_data[2:0]; // see RULE15
          end
        end
        A_PTR:  s_nxt.ptr  = i_wr_data;
        A_PA:   s_nxt.pa   = i_wr_data; // see RULE21
        A_PB:   s_nxt.pb   = i_wr_data; // see RULE21
        A_POWER_CONTROL: s_nxt.power_control = i_wr_data & POWER_CONTROL_MASK; // see RULE23
        A_PCHB: s_nxt.pchb = i_wr_data & PCHB_MASK;
        default: begin
          if (gpr_wr) begin
            s_nxt.gpr[wr_ea] = i_wr_data;
          end
        end
      endcase
    end

    // Flags from the executing operation override any write
    unique case (i_alu_kind)
      ALU_NONE: begin
      end
      ALU_ADD, ALU_SUB: begin
        s_nxt.stat[ST_C]  = sum9[8]; // see RULE16
        s_nxt.stat[ST_DC] = half5[4]; // see RULE17
        s_nxt.stat[ST_Z]  = (i_alu_res == 8'h00); // see RULE18
      end
      ALU_ROTL: s_nxt.stat[ST_C] = i_alu_a[7]; // see RULE16
      ALU_ROTR: s_nxt.stat[ST_C] = i_alu_a[0]; // see RULE16
      ALU_LOGIC: s_nxt.stat[ST_Z] = (i_alu_res == 8'h00); // see RULE18
      default: begin
      end
    endcase

    // Reset cause flags; a set in the same cycle wins
    if (i_wdt_ovf) begin
      s_nxt.stat[ST_TO] = 1'b0; // see RULE20
    end
    if (i_sleep) begin
      s_nxt.stat[ST_PD] = 1'b0; // see RULE19
      s_nxt.stat[ST_TO] = 1'b1; // see RULE20
    end
    if (i_clear_watchdog_instruction) begin
      s_nxt.stat[ST_PD] = 1'b1; // see RULE19
      s_nxt.stat[ST_TO] = 1'b1; // see RULE20
    end

    // Program counter and stack; deepest entry is lost on overflow
    if (i_icyc) begin
      if (i_jump) begin
        s_nxt.pc = i_target; // see RULE11
      end else if (i_call) begin
        for (int i = STK_N - 1; i > 0; i--) begin
          s_nxt.stk[i] = s_r.stk[i-1];
        end
        s_nxt.stk[0] = s_r.pc; // see RULE12
        s_nxt.pc = i_target; // see RULE12
      end else if (i_ret) begin
        for (int i = 0; i < STK_N - 1; i++) begin
          s_nxt.stk[i] = s_r.stk[i+1];
        end
        s_nxt.pc = s_r.stk[0]; // see RULE13 see RULE9
      end else if (i_wr && (wr_ea == A_PCL)) begin
        s_nxt.pc = {s_r.pchb[1:0], i_wr_data}; // see RULE14
      end else begin
        s_nxt.pc = s_r.pc + 10'h001; // see RULE10
      end
    end

    // Port B pin 0 goes either to interrupt or to change detect
    s_nxt.ext_int  = s_r.power_control[PC_EIS] & i_pb_pins[0]; // see RULE22
    s_nxt.chg_mask = {7'h7f, ~s_r.power_control[PC_EIS]}; // see RULE22
  end

  ////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= SFR_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs

  assign o_rd_data     = s_r.rd_data;
  assign o_pc          = s_r.pc;
  assign o_status      = s_r.stat;
  assign o_tmr_ovf     = s_r.tmr_ovf;
  assign o_pa_latch    = s_r.pa;
  assign o_pb_latch    = s_r.pb;
  assign o_wdt_en      = s_r.power_control[PC_WDT]; // see RULE23
  assign o_lvd_en      = s_r.power_control[PC_LVD]; // see RULE23
  assign o_roc_en      = s_r.power_control[PC_ROC]; // see RULE23
  assign o_ext_int     = s_r.ext_int;
  assign o_pb_chg_mask = s_r.chg_mask;

endmodule // sfr_bank

// ### include/sfr_pkg.sv
// Constants and state type for the special function register bank.
// Assumes a 6-bit data address space and an 8-bit data path.
package sfr_pkg;

  localparam logic [5:0] A_IND    = 6'h00;
  localparam logic [5:0] A_TMR    = 6'h01;
  localparam logic [5:0] A_PCL    = 6'h02;
  localparam logic [5:0] A_STAT   = 6'h03;
  localparam logic [5:0] A_PTR    = 6'h04;
  localparam logic [5:0] A_PA     = 6'h05;
  localparam logic [5:0] A_PB     = 6'h06;
  localparam logic [5:0] A_GPR0   = 6'h07;
  localparam logic [5:0] A_POWER_CONTROL   = 6'h08;
  localparam logic [5:0] A_PCHB   = 6'h0a;
  localparam logic [5:0] A_GPR_LO = 6'h10;

  localparam int ST_C   = 0;
  localparam int ST_DC  = 1;
  localparam int ST_Z   = 2;
  localparam int ST_PD  = 3;
  localparam int ST_TO  = 4;
  localparam int OPT_CS = 5;
  localparam int OPT_SE = 4;
  localparam int OPT_PA = 3;
  localparam int PC_WDT = 7;
  localparam int PC_EIS = 6;
  localparam int PC_LVD = 5;
  localparam int PC_ROC = 4;
  localparam int STK_N  = 5;

  localparam logic [9:0] PC_RESET   = 10'h3ff;
  localparam logic [7:0] STAT_RESET = 8'h18;
  localparam logic [7:0] PTR_ONES   = 8'hc0;
  localparam logic [7:0] POWER_CONTROL_MASK  = 8'hf0;
  localparam logic [7:0] PCHB_MASK  = 8'h03;
  localparam logic [7:0] STAT_FREE  = 8'he0;

  typedef enum logic [5:0] {
    ALU_NONE  = 6'b000001,
    ALU_ADD   = 6'b000010,
    ALU_SUB   = 6'b000100,
    ALU_ROTL  = 6'b001000,
    ALU_ROTR  = 6'b010000,
    ALU_LOGIC = 6'b100000
  } sfr_alu_t;

  typedef struct packed {
    logic [9:0]            pc;
    logic [STK_N-1:0][9:0] stk;
    logic [63:0][7:0]      gpr;
    logic [7:0]            tmr;
    logic [7:0]            presc;
    logic [7:0]            opt;
    logic [7:0]            stat;
    logic [7:0]            ptr;
    logic [7:0]            pa;
    logic [7:0]            pb;
    logic [7:0]            power_control;
    logic [7:0]            pchb;
    logic                  pin_prev;
    logic [7:0]            rd_data;
    logic                  tmr_ovf;
    logic                  ext_int;
    logic [7:0]            chg_mask;
  } sfr_state_t;

  localparam sfr_state_t SFR_RESET = '{
    pc: PC_RESET, stat: STAT_RESET, chg_mask: 8'hff, default: '0};

endpackage

// ### tb/sfr_pin_model.sv
// Far side model: external timer clock pin driven by the board.
// Assumes the bench raises i_run for as many edges as it wants toggles.
`timescale 1ns/1ps

module sfr_pin_model (
  input  wire logic i_clk,
  input  wire logic i_run,
  output logic      o_pin
);
  initial o_pin = 1'b0;
  // Pin stands still outside runs, so counts stay exact
  always @(posedge i_clk) begin
    if (i_run) o_pin <= ~o_pin;
  end
endmodule // sfr_pin_model

// ### tb/sfr_bank_props.sv
// Checker for the special function register bank.
// Sees only top-level ports; attached by the bind below.
`timescale 1ns/1ps

module sfr_bank_props
  import sfr_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_icyc,
  input wire logic       i_rd,
  input wire logic [5:0] i_rd_addr,
  input wire logic       i_wr,
  input wire logic [5:0] i_wr_addr,
  input wire logic       i_jump,
  input wire logic       i_call,
  input wire logic       i_ret,
  input wire logic [9:0] i_target,
  input wire logic       i_clear_watchdog_instruction,
  input wire logic       i_sleep,
  input wire logic       i_wdt_ovf,
  input wire logic [7:0] o_rd_data,
  input wire logic [9:0] o_pc,
  input wire logic [7:0] o_status,
  input wire logic       o_ext_int,
  input wire logic [7:0] o_pb_chg_mask
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////
  pc_advance_a: assert property (i_icyc && !(i_jump || i_call || i_ret)
    && !(i_wr && (i_wr_addr == A_PCL || i_wr_addr == A_IND))
    |=> o_pc == $past(o_pc) + 10'h1)
    else $error("pc did not advance");
  jump_load_a: assert property (i_icyc && i_jump |=> o_pc == $past(i_target))
    else $error("jump target not loaded");
  ptr_ones_a: assert property (i_rd && i_rd_addr == A_PTR |=> o_rd_data[7:6] == 2'b11)
    else $error("pointer top bits not one");
  power_control_low_a: assert property (i_rd && i_rd_addr == A_POWER_CONTROL |=> o_rd_data[3:0] == 4'h0)
    else $error("power control low bits not zero");
  sleep_flags_a: assert property (i_sleep && !i_clear_watchdog_instruction |=>
    o_status[ST_TO] && !o_status[ST_PD]) else $error("sleep flags wrong");
  clear_watchdog_instruction_flags_a: assert property (i_clear_watchdog_instruction && !i_sleep |=>
    o_status[ST_TO] && o_status[ST_PD]) else $error("clear watchdog flags wrong");
  wdt_timeout_a: assert property (i_wdt_ovf && !i_clear_watchdog_instruction && !i_sleep |=>
    !o_status[ST_TO]) else $error("timeout flag not cleared");
  ext_mask_a: assert property (o_ext_int |-> !o_pb_chg_mask[0])
    else $error("change path open while interrupt active");
endmodule // sfr_bank_props

bind sfr_bank sfr_bank_props sfr_bank_props_i (.i_clk, .i_rstn, .i_icyc, .i_rd,
  .i_rd_addr, .i_wr, .i_wr_addr, .i_jump, .i_call, .i_ret, .i_target, .i_clear_watchdog_instruction,
  .i_sleep, .i_wdt_ovf, .o_rd_data, .o_pc, .o_status, .o_ext_int, .o_pb_chg_mask);

// ### tb/sfr_bank_test.sv
// Self-checking bench for the special function register bank.
// Drives the core side at falling edges; pin model drives the timer pin.
`timescale 1ns/1ps

module sfr_bank_test;
  import sfr_pkg::*;
  logic       i_clk = 0, i_rstn = 0, i_icyc = 0, i_rd = 0, i_wr = 0, i_opt_wr = 0;
  logic       i_jump = 0, i_call = 0, i_ret = 0, i_clear_watchdog_instruction = 0, i_sleep = 0, i_wdt_ovf = 0;
  logic       run = 0, tmr_pin, o_tmr_ovf, o_wdt_en, o_lvd_en, o_roc_en, o_ext_int;
  logic [5:0] i_rd_addr = 0, i_wr_addr = 0;
  logic [7:0] i_wr_data = 0, i_opt_data = 0, i_alu_a = 0, i_alu_b = 0, i_alu_res = 0;
  logic [7:0] i_pa_pins = 0, i_pb_pins = 0, o_rd_data, o_status, o_pb_chg_mask;
  logic [7:0] o_pa_latch, o_pb_latch;
  logic [9:0] i_target = 0, o_pc;
  sfr_alu_t   i_alu_kind = ALU_NONE;
  int         error_cnt = 0, tests_run = 0;
  always #2.5 i_clk = ~i_clk;
  sfr_pin_model sfr_pin_model_i (.i_clk, .i_run(run), .o_pin(tmr_pin));
  sfr_bank sfr_bank_i (.i_clk, .i_rstn, .i_icyc, .i_rd, .i_rd_addr, .i_wr, .i_wr_addr,
    .i_wr_data, .i_opt_wr, .i_opt_data, .i_jump, .i_call, .i_ret, .i_target, .i_alu_kind,
    .i_alu_a, .i_alu_b, .i_alu_res, .i_clear_watchdog_instruction, .i_sleep, .i_wdt_ovf, .i_tmr_pin(tmr_pin),
    .i_pa_pins, .i_pb_pins, .o_rd_data, .o_pc, .o_status, .o_tmr_ovf, .o_pa_latch,
    .o_pb_latch, .o_wdt_en, .o_lvd_en, .o_roc_en, .o_ext_int, .o_pb_chg_mask);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_clk) {i_wr, i_wr_addr, i_wr_data} = {1'b1, a, d};
    @(negedge i_clk) i_wr = 0;
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    @(negedge i_clk) {i_rd, i_rd_addr} = {1'b1, a};
    @(negedge i_clk) i_rd = 0;
    check(o_rd_data, e);
  endtask
  task automatic ticks(input int n);
    @(negedge i_clk) i_icyc = 1;
    repeat (n) @(negedge i_clk);
    {i_icyc, i_jump, i_call, i_ret} = 0;
  endtask
  // Flow lines rise a cycle before icyc, so the ignore path is exercised too
  task automatic step(input logic [2:0] jcr, input logic [9:0] t);
    {i_jump, i_call, i_ret, i_target} = {jcr, t};
    ticks(1);
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_clk) s = 1;
    @(negedge i_clk) s = 0;
  endtask
  task automatic alu(input sfr_alu_t k, input logic [7:0] a, b, r, input logic [2:0] f);
    @(negedge i_clk) {i_alu_a, i_alu_b, i_alu_res} = {a, b, r};
    i_alu_kind = k;
    @(negedge i_clk) i_alu_kind = ALU_NONE;
    check(o_status[2:0], f);
  endtask
  task automatic opt(input logic [7:0] d);
    @(negedge i_clk) {i_opt_wr, i_opt_data} = {1'b1, d};
    @(negedge i_clk) i_opt_wr = 0;
  endtask
  task automatic pins(input int n);
    @(negedge i_clk) run = 1;
    repeat (n) @(negedge i_clk);
    run = 0;
    repeat (3) @(negedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_pc();
    check(o_pc, PC_RESET);
    ticks(2);
    check(o_pc, 10'h001);
    for (int i = 1; i <= 5; i++) step(3'b010, 10'(i * 64));
    check(o_pc, 10'h140);
    for (int i = 4; i >= 0; i--) begin
      step(3'b001, 10'h0);
      check(o_pc, i > 0 ? 10'(i * 64) : 10'h001);
    end
    wr(A_PCHB, 8'h03);
    step(3'b100, 10'h2aa);
    check(o_pc, 10'h2aa);
    rc(A_PCHB, 8'h03);
    i_icyc = 1;
    wr(A_PCL, 8'h45);
    i_icyc = 0;
    check(o_pc, 10'h345);
    rc(A_PCL, 8'h45);
  endtask
  task automatic t_indirect();
    wr(6'h38, 8'h10);
    wr(A_PTR, 8'h78);
    rc(A_PTR, 8'hf8);
    rc(A_IND, 8'h10);
    wr(A_GPR0, 8'haa);
    wr(A_PTR, 8'h00);
    wr(A_IND, 8'h55);
    rc(A_IND, 8'h00);
    rc(A_GPR0, 8'haa);
    rc(6'h38, 8'h10);
  endtask
  task automatic t_flags();
    alu(ALU_ADD, 8'h0f, 8'h01, 8'h10, 3'b010);
    alu(ALU_ADD, 8'hf0, 8'h10, 8'h00, 3'b101);
    alu(ALU_SUB, 8'h05, 8'h05, 8'h00, 3'b111);
    alu(ALU_SUB, 8'h00, 8'h01, 8'hff, 3'b000);
    alu(ALU_ROTL, 8'h80, 8'h00, 8'h00, 3'b001);
    alu(ALU_LOGIC, 8'h00, 8'h00, 8'h00, 3'b101);
    wr(A_STAT, 8'hff);
    check(o_status, 8'hff);
    pulse(i_sleep);
    check(o_status, 8'hf7);
    wr(A_STAT, 8'h00);
    check(o_status, 8'h10);
    pulse(i_clear_watchdog_instruction);
    check(o_status, 8'h18);
    pulse(i_wdt_ovf);
    check(o_status, 8'h08);
    // Status write in a flag-setting cycle keeps the ALU flags
    @(negedge i_clk) {i_wr, i_wr_addr, i_wr_data} = {1'b1, A_STAT, 8'he7};
    {i_alu_a, i_alu_b, i_alu_res} = {8'h01, 8'h01, 8'h02};
    i_alu_kind = ALU_ADD;
    @(negedge i_clk) i_wr = 0;
    i_alu_kind = ALU_NONE;
    check(o_status, 8'he8);
  endtask
  task automatic t_timer();
    opt(8'h08);
    wr(A_TMR, 8'hfe);
    ticks(2);
    check(o_tmr_ovf, 1'b1);
    rc(A_TMR, 8'h00);
    check(o_tmr_ovf, 1'b0);
    opt(8'h28);
    wr(A_TMR, 8'h00);
    pins(3);
    rc(A_TMR, 8'h02);
    opt(8'h38);
    wr(A_TMR, 8'h00);
    pins(1);
    rc(A_TMR, 8'h01);
    opt(8'h00);
    wr(A_TMR, 8'h00);
    ticks(1);
    wr(A_TMR, 8'h00);
    ticks(1);
    rc(A_TMR, 8'h00);
    ticks(1);
    rc(A_TMR, 8'h01);
  endtask
  task automatic t_ports();
    i_pa_pins = 8'h3c;
    i_pb_pins = 8'h01;
    wr(A_PA, 8'ha5);
    check(o_pa_latch, 8'ha5);
    wr(A_PB, 8'h5a);
    check(o_pb_latch, 8'h5a);
    rc(A_PA, 8'h3c);
    rc(A_PB, 8'h01);
    wr(A_POWER_CONTROL, 8'hff);
    rc(A_POWER_CONTROL, 8'hf0);
    check({o_wdt_en, o_lvd_en, o_roc_en, o_ext_int}, 4'hf);
    check(o_pb_chg_mask, 8'hfe);
    wr(A_POWER_CONTROL, 8'h00);
    rc(A_POWER_CONTROL, 8'h00);
    check({o_ext_int, o_pb_chg_mask}, 9'h0ff);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge i_clk);
    i_rstn = 1;
    t_pc();
    t_indirect();
    t_flags();
    t_timer();
    t_ports();
    conclude();
  end
  // Whole run is under two hundred cycles; this leaves wide margin
  initial begin
    #20000;
    error_cnt++;
    conclude();
  end
endmodule // sfr_bank_test
